/* design/pcp_ctrl.sv */
// interrupt controller configuration, priority levels and winner capture
//
// Overview of operation
// - source request to core notification within 4 core cycles, gateway sync included.
// - source ids start at 1 and are contiguous up to the source count.
// - reserved and unused register bits always read as zero.
// - source count is a build parameter from 2 to 255.
// - source id fields and buses are sized for 255 sources.
// - read/write registers take any value and read back only legal values.
// - only word-sized, word-aligned accesses; others get a load or store fault.
// - unused window addresses: no fault, reads return zero, writes dropped.
// - config bit 0 picks priority order: 0 standard, 1 reversed.
// - 4-bit priority per source; 0 (or 15 reversed) never interrupts.
// - one separate priority register per source.
// - priority read and write paths invert when the order is reversed.
// - taking an external interrupt disables further interrupts until re-enabled.
// - capture trigger latches winning id and its priority together.
// - up to 15 nested handlers, higher priority preempts lower.
// - capture trigger takes any write and reads zero, holds nothing.
// - request registered: asserted one cycle after max priority exceeds threshold and current, and only while enabled.
`timescale 1ns/1ps
module pcp_ctrl
  import pcp_pkg::*;
#(
  parameter int N_SRC = PCP_MAX_SRC,
  parameter logic [31:0] BASE_ADDR = PCP_BASE_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // memory-mapped register port
  input wire logic bus_req_i,
  input wire logic bus_we_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic [1:0] bus_size_i,
  input wire logic [31:0] bus_wdata_i,
  output logic bus_ready_o,
  output logic bus_ack_o,
  output logic bus_ld_fault_o,
  output logic bus_st_fault_o,
  output logic [31:0] bus_rdata_o,
  // from gateways and enable registers
  input wire logic [N_SRC:1] src_pend_i,
  input wire logic [N_SRC:1] src_enable_i,
  // core-side priority thresholds, software encoding
  input wire logic [3:0] prio_thresh_i,
  input wire logic [3:0] cur_prio_i,
  // capture trigger write and core interrupt handshake
  input wire logic cap_trig_we_i,
  input wire logic irq_taken_i,
  input wire logic irq_reenable_i,
  output logic irq_o,
  output logic irq_enabled_o,
  output logic [7:0] claim_id_o,
  output logic [3:0] claim_prio_o,
  output logic [31:0] cap_trig_rdata_o,
  output logic order_rev_o
);
  pcp_prio_if pif ();

  pcp_prio_mem #(
    .N_SRC(N_SRC)
  ) u_mem (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .pif(pif)
  );

  // software view to internal standard order and back
  function automatic logic [3:0] pcp_conv(input logic [3:0] v, input logic rev);
    pcp_conv = v ^ {PCP_PRIO_W{rev}};
  endfunction : pcp_conv

  logic order_r;
  pcp_bus_st_e st_r;
  logic [31:0] rdata_r;
  logic ack_r;
  logic ld_fault_r;
  logic st_fault_r;
  logic rd_prio_r;
  logic rd_cfg_r;

  // decode
  logic [14:0] ofs;
  logic in_win;
  logic fmt_ok;
  logic hit_cfg;
  logic hit_prio;
  logic [7:0] src_id;
  logic take;

  assign ofs = bus_addr_i[PCP_WIN_W-1:0];
  assign in_win = (bus_addr_i[31:PCP_WIN_W] == BASE_ADDR[31:PCP_WIN_W]);
  assign fmt_ok = (bus_size_i == PCP_SIZE_WORD) && (bus_addr_i[1:0] == PCP_ALIGN_OK);
  assign src_id = ofs[9:2];
  assign hit_cfg = (ofs == PCP_OFS_CFG);
  // id 0 and ids past N_SRC fall through as unused addresses
  assign hit_prio = (ofs <= PCP_OFS_PRIO_LAST) && (src_id != PCP_ID_NONE)
                    && (int'(src_id) <= N_SRC);
  assign take = bus_req_i && (st_r == PCP_IDLE);
  assign bus_ready_o = (st_r == PCP_IDLE);

  // priority store write and read paths
  assign pif.we = take && bus_we_i && fmt_ok && in_win && hit_prio;
  assign pif.waddr = src_id;
  assign pif.wdata = pcp_conv(bus_wdata_i[3:0], order_r);
  assign pif.raddr = src_id;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      order_r <= PCP_CFG_RESET;
    end else if (take && bus_we_i && fmt_ok && in_win && hit_cfg) begin
      order_r <= bus_wdata_i[PCP_CFG_ORDER_BIT];
    end
  end

  // bus sequencing: reads need one extra cycle for the registered store
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= PCP_IDLE;
      rd_prio_r <= 1'b0;
      rd_cfg_r <= 1'b0;
      ld_fault_r <= 1'b0;
      st_fault_r <= 1'b0;
    end else begin
      case (st_r)
        PCP_IDLE: begin
          if (take) begin
            st_r <= PCP_READ;
            rd_prio_r <= !bus_we_i && fmt_ok && in_win && hit_prio;
            rd_cfg_r <= !bus_we_i && fmt_ok && in_win && hit_cfg;
            ld_fault_r <= !bus_we_i && !fmt_ok;
            st_fault_r <= bus_we_i && !fmt_ok;
          end
        end
        PCP_READ: st_r <= PCP_DONE;
        PCP_DONE: st_r <= PCP_IDLE;
        default: st_r <= PCP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= PCP_ZERO;
      ack_r <= 1'b0;
    end else begin
      ack_r <= (st_r == PCP_READ);
      if (st_r == PCP_READ) begin
        // unused addresses and reserved bits read zero
        rdata_r <= PCP_ZERO;
        if (rd_prio_r) begin
          rdata_r[3:0] <= pcp_conv(pif.rdata, order_r);
        end
        if (rd_cfg_r) begin
          rdata_r[PCP_CFG_ORDER_BIT] <= order_r;
        end
      end
    end
  end

  assign bus_ack_o = ack_r;
  assign bus_rdata_o = rdata_r;
  assign bus_ld_fault_o = ack_r && ld_fault_r;
  assign bus_st_fault_o = ack_r && st_fault_r;

  // winner search: strict compare keeps the lowest id on ties
  logic [3:0] max_prio;
  logic [7:0] max_id;
  logic [3:0] eff_prio;
  always_comb begin
    max_prio = PCP_PRIO_NEVER;
    max_id = PCP_ID_NONE;
    eff_prio = PCP_PRIO_NEVER;
    for (int s = 1; s <= N_SRC; s++) begin
      eff_prio = (src_pend_i[s] && src_enable_i[s])
                 ? pif.prio_vec[s*PCP_PRIO_W +: PCP_PRIO_W] : PCP_PRIO_NEVER;
      if (eff_prio > max_prio) begin
        max_prio = eff_prio;
        max_id = s[7:0];
      end
    end
  end

  logic [3:0] thr_int;
  logic [3:0] cur_int;
  logic [3:0] gate_lvl;
  assign thr_int = pcp_conv(prio_thresh_i, order_r);
  assign cur_int = pcp_conv(cur_prio_i, order_r);
  assign gate_lvl = (thr_int > cur_int) ? thr_int : cur_int;

  // one register stage keeps the pic core well inside the latency budget
  logic req_r;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_r <= 1'b0;
    end else begin
      req_r <= (max_prio > gate_lvl);
    end
  end

  // global enable; set by software re-enable, cleared on take
  logic irq_en_r;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_en_r <= 1'b0;
    end else if (irq_taken_i) begin
      irq_en_r <= 1'b0;
    end else if (irq_reenable_i) begin
      irq_en_r <= 1'b1;
    end
  end

  assign irq_o = req_r && irq_en_r;
  assign irq_enabled_o = irq_en_r;

  // capture ignores thresholds and the global enable so id and level stay a pair
  logic [7:0] claim_id_r;
  logic [3:0] claim_prio_r;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      claim_id_r <= PCP_ID_NONE;
      claim_prio_r <= PCP_PRIO_RESET;
    end else if (cap_trig_we_i) begin
      claim_id_r <= max_id;
      claim_prio_r <= max_prio;
    end
  end

  assign claim_id_o = claim_id_r;
  assign claim_prio_o = pcp_conv(claim_prio_r, order_r);
  assign cap_trig_rdata_o = PCP_ZERO;
  assign order_rev_o = order_r;
endmodule : pcp_ctrl

/* design/pcp_pkg.sv */
// shared constants for the priority and configuration block
package pcp_pkg;
  localparam int PCP_MAX_SRC = 255;
  localparam int PCP_ID_W = 8;
  localparam int PCP_PRIO_W = 4;
  localparam int PCP_DATA_W = 32;
  localparam int PCP_WIN_W = 15;
  localparam logic [31:0] PCP_BASE_DEF = 32'hF00C_0000;
  localparam logic [14:0] PCP_OFS_CFG = 15'h3000;
  localparam logic [14:0] PCP_OFS_PRIO_LAST = 15'h03FC;
  localparam logic [1:0] PCP_SIZE_WORD = 2'h2;
  localparam logic [1:0] PCP_ALIGN_OK = 2'h0;
  localparam int PCP_CFG_ORDER_BIT = 0;
  localparam logic PCP_CFG_RESET = 1'h0;
  localparam logic [3:0] PCP_PRIO_RESET = 4'h0;
  localparam logic [3:0] PCP_PRIO_NEVER = 4'h0;
  localparam logic [7:0] PCP_ID_NONE = 8'h00;
  localparam logic [31:0] PCP_ZERO = 32'h0000_0000;
  localparam int PCP_LATENCY_CYC = 4;

  typedef enum logic [1:0] {
    PCP_IDLE = 2'b00,
    PCP_READ = 2'b01,
    PCP_DONE = 2'b10
  } pcp_bus_st_e;
endpackage : pcp_pkg

/* design/pcp_prio_if.sv */
// carrier between the control logic and the priority store
`timescale 1ns/1ps
interface pcp_prio_if;
  import pcp_pkg::*;
  logic we;
  logic [PCP_ID_W-1:0] waddr;
  logic [PCP_PRIO_W-1:0] wdata;
  logic [PCP_ID_W-1:0] raddr;
  logic [PCP_PRIO_W-1:0] rdata;
  logic [PCP_PRIO_W*(PCP_MAX_SRC+1)-1:0] prio_vec;
  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata, input prio_vec);
  modport store (input we, input waddr, input wdata, input raddr,
                 output rdata, output prio_vec);
endinterface : pcp_prio_if

/* design/pcp_prio_mem.sv */
// per-source priority store, registered read port plus flat view
`timescale 1ns/1ps
module pcp_prio_mem
  import pcp_pkg::*;
#(
  parameter int N_SRC = PCP_MAX_SRC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  pcp_prio_if.store pif
);
  logic [PCP_PRIO_W-1:0] mem_r [0:PCP_MAX_SRC];
  logic [PCP_PRIO_W-1:0] rdata_r;

  // ids above N_SRC and id 0 are never written and read as zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i <= PCP_MAX_SRC; i++) begin
        mem_r[i] <= PCP_PRIO_RESET;
      end
    end else if (pif.we && pif.waddr != PCP_ID_NONE && int'(pif.waddr) <= N_SRC) begin
      mem_r[pif.waddr] <= pif.wdata;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= PCP_PRIO_RESET;
    end else begin
      rdata_r <= mem_r[pif.raddr];
    end
  end

  assign pif.rdata = rdata_r;

  genvar g;
  for (g = 0; g <= PCP_MAX_SRC; g++) begin : g_flat
    assign pif.prio_vec[g*PCP_PRIO_W +: PCP_PRIO_W] = mem_r[g];
  end
endmodule : pcp_prio_mem

/* test/pcp_ctrl_sva.sv */
// bus and interrupt handshake assertions for pcp_ctrl
`timescale 1ns/1ps
module pcp_ctrl_sva
  import pcp_pkg::*;
#(
  parameter int N_SRC = PCP_MAX_SRC,
  parameter logic [31:0] BASE_ADDR = PCP_BASE_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic bus_req_i,
  input wire logic bus_we_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic [1:0] bus_size_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic bus_ready_o,
  input wire logic bus_ack_o,
  input wire logic bus_ld_fault_o,
  input wire logic bus_st_fault_o,
  input wire logic [31:0] cap_trig_rdata_o,
  input wire logic [N_SRC:1] src_pend_i,
  input wire logic [N_SRC:1] src_enable_i,
  input wire logic irq_taken_i,
  input wire logic irq_reenable_i,
  input wire logic irq_o,
  input wire logic irq_enabled_o,
  input wire logic order_rev_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_take;
    bus_req_i && bus_ready_o;
  endsequence
  sequence s_bad;
    s_take ##0 (bus_size_i != PCP_SIZE_WORD || bus_addr_i[1:0] != PCP_ALIGN_OK);
  endsequence
  a_ack_two_cycles: assert property (s_take |=> (!bus_ready_o && !bus_ack_o) ##1
    (bus_ack_o && !bus_ready_o) ##1 bus_ready_o) else $error("ack timing wrong");
  a_ack_needs_take: assert property (bus_ack_o |-> $past(bus_req_i && bus_ready_o, 2))
    else $error("ack without request");
  a_load_fault: assert property (s_bad ##0 !bus_we_i |->
    ##2 bus_ld_fault_o && !bus_st_fault_o) else $error("load fault missing");
  a_store_fault: assert property (s_bad ##0 bus_we_i |->
    ##2 bus_st_fault_o && !bus_ld_fault_o) else $error("store fault missing");
  a_fault_with_ack: assert property ((bus_ld_fault_o || bus_st_fault_o) |-> bus_ack_o)
    else $error("fault without ack");
  a_trig_reads_zero: assert property (cap_trig_rdata_o == PCP_ZERO)
    else $error("capture trigger not zero");
  a_irq_gated: assert property (irq_o |-> irq_enabled_o)
    else $error("irq while disabled");
  a_taken_disables: assert property (irq_taken_i |=> !irq_enabled_o)
    else $error("enable not cleared");
  a_reenable_sets: assert property (irq_reenable_i && !irq_taken_i |=> irq_enabled_o)
    else $error("enable not set");
  a_order_write: assert property (s_take ##0 (bus_we_i && bus_size_i == PCP_SIZE_WORD &&
    bus_addr_i == BASE_ADDR + 32'(PCP_OFS_CFG)) |=> order_rev_o == $past(bus_wdata_i[0]))
    else $error("order bit not written");
  // request is registered, so an idle source set silences irq one edge later
  a_no_source_quiet: assert property ((src_pend_i & src_enable_i) == '0 |=> !irq_o)
    else $error("irq with nothing pending");
endmodule : pcp_ctrl_sva
bind pcp_ctrl pcp_ctrl_sva #(.N_SRC(N_SRC), .BASE_ADDR(BASE_ADDR)) u_sva (.*);

/* test/pcp_core_model.sv */
// core and handler firmware stand-in: takes, captures, re-enables
`timescale 1ns/1ps
module pcp_core_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic irq_i,
  input wire logic reen_req_i,
  output logic taken_o,
  output logic reenable_o,
  output logic cap_o
);
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      taken_o <= 1'b0;
      cap_o <= 1'b0;
      reenable_o <= 1'b0;
    end else begin
      taken_o <= irq_i && !taken_o;
      cap_o <= taken_o;
      reenable_o <= reen_req_i;
    end
  end
endmodule : pcp_core_model

/* test/test_pcp_ctrl.sv */
// register and interrupt tests for pcp_ctrl
`timescale 1ns/1ps
module test_pcp_ctrl;
  import pcp_pkg::*;
  localparam int NS = 4;
  localparam logic [31:0] BA = PCP_BASE_DEF;
  localparam logic [1:0] W = PCP_SIZE_WORD;
  logic clk_sys_i = 0, rst_n_i = 0, bus_req_i = 0, bus_we_i = 0, reen_req = 0;
  logic [31:0] bus_addr_i = '0, bus_wdata_i = '0, bus_rdata_o, cap_trig_rdata_o;
  logic [1:0] bus_size_i = W;
  logic [NS:1] src_pend_i = '0, src_enable_i = '0;
  logic [3:0] prio_thresh_i = '0, cur_prio_i = '0, claim_prio_o;
  logic cap_trig_we_i, irq_taken_i, irq_reenable_i, bus_ready_o, bus_ack_o;
  logic bus_ld_fault_o, bus_st_fault_o, irq_o, irq_enabled_o, order_rev_o;
  logic [7:0] claim_id_o;
  int num_errors = 0, compares = 0, cyc = 0, i;
  always #10 clk_sys_i = ~clk_sys_i;
  pcp_ctrl #(.N_SRC(NS), .BASE_ADDR(BA)) dut (.*);
  pcp_core_model core (.clk_sys_i, .rst_n_i, .irq_i(irq_o), .reen_req_i(reen_req),
    .taken_o(irq_taken_i), .reenable_o(irq_reenable_i), .cap_o(cap_trig_we_i));
  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one access; the next starts only after the answer, as a fence would ensure
  task automatic acc(input logic we, input int ofs, input logic [1:0] sz,
                     input logic [31:0] wd, input logic [31:0] exp, input logic flt);
    int n;
    @(negedge clk_sys_i);
    bus_req_i = 1;
    bus_we_i = we;
    bus_addr_i = BA + 32'(ofs);
    bus_size_i = sz;
    bus_wdata_i = wd;
    n = 0;
    // ready seen at a falling edge is what the next rising edge samples
    while (bus_ready_o !== 1'b1 && n++ < 8) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    bus_req_i = 0;
    n = 0;
    while (bus_ack_o !== 1'b1 && n++ < 8) @(negedge clk_sys_i);
    chk("ack", {31'h0, bus_ack_o}, 32'h1);
    chk("fault", {30'h0, bus_ld_fault_o, bus_st_fault_o}, {30'h0, flt && !we, flt && we});
    if (!we) chk("rdata", bus_rdata_o, exp);
  endtask : acc
  // irq must show within the latency target; the core model takes it at once
  task automatic wait_irq(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (PCP_LATENCY_CYC) begin
      @(negedge clk_sys_i);
      seen = seen | irq_o;
    end
    chk("irq", {31'h0, seen}, {31'h0, exp});
  endtask : wait_irq
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(negedge clk_sys_i);
    rst_n_i = 1;
    acc(0, PCP_OFS_CFG, W, 0, 0, 0);
    for (i = 1; i <= NS; i++) acc(0, i * 4, W, 0, 0, 0);
    for (i = 1; i <= NS; i++) acc(1, i * 4, W, 32'hFFFF_FFF0 | i, 0, 0);
    for (i = 1; i <= NS; i++) acc(0, i * 4, W, 0, i, 0);
    acc(1, 32'h0000_3004, W, 32'hFFFF_FFFF, 0, 0);
    acc(0, 32'h0000_3004, W, 0, 0, 0);
    acc(0, 0, W, 0, 0, 0);
    acc(0, (NS + 1) * 4, W, 0, 0, 0);
    acc(0, 6, W, 0, 0, 1);
    acc(1, 4, 2'h1, 32'h0000_0009, 0, 1);
    acc(0, 4, W, 0, 32'h0000_0001, 0);
    acc(1, PCP_OFS_CFG, W, 32'hFFFF_FFFF, 0, 0);
    acc(0, PCP_OFS_CFG, W, 0, 32'h0000_0001, 0);
    acc(0, 8, W, 0, 32'h0000_000D, 0);
    acc(1, 8, W, 32'h0000_0005, 0, 0);
    acc(1, PCP_OFS_CFG, W, 0, 0, 0);
    acc(0, 8, W, 0, 32'h0000_000A, 0);
    acc(1, 12, W, 32'h0000_000A, 0, 0);
    chk("captrig", cap_trig_rdata_o, 0);
    chk("enabled", {31'h0, irq_enabled_o}, 0);
    reen_req = 1;
    @(negedge clk_sys_i);
    reen_req = 0;
    src_enable_i = '1;
    src_pend_i = '1;
    wait_irq(1);
    repeat (4) @(negedge clk_sys_i);
    chk("enabled", {31'h0, irq_enabled_o}, 0);
    chk("claim_id", {24'h0, claim_id_o}, 32'h0000_0002);
    chk("claim_prio", {28'h0, claim_prio_o}, 32'h0000_000A);
    prio_thresh_i = 4'hA;
    reen_req = 1;
    @(negedge clk_sys_i);
    reen_req = 0;
    wait_irq(0);
    // current priority alone must mask and then let a higher level through
    prio_thresh_i = 4'h0;
    cur_prio_i = 4'hA;
    wait_irq(0);
    cur_prio_i = 4'h9;
    wait_irq(1);
    src_pend_i = '0;
    final_report();
  end
endmodule : test_pcp_ctrl
